// >>> hw/bpm_pkg.sv
// Package with register map, field positions and types for the PWM mask block
package bpm_pkg;
  localparam int unsigned BPM_ADDR_W = 6;
  // Byte addresses of the 32-bit register words
  localparam logic [5:0] BPM_DUTY0_LOW_ADDR   = 6'h00;
  localparam logic [5:0] BPM_DUTY0_HIGH_ADDR  = 6'h04;
  localparam logic [5:0] BPM_DUTY1_LOW_ADDR   = 6'h08;
  localparam logic [5:0] BPM_DUTY1_HIGH_ADDR  = 6'h0C;
  localparam logic [5:0] BPM_DUTY2_LOW_ADDR   = 6'h10;
  localparam logic [5:0] BPM_DUTY2_HIGH_ADDR  = 6'h14;
  localparam logic [5:0] BPM_PERIOD_LOW_ADDR  = 6'h18;
  localparam logic [5:0] BPM_PERIOD_HIGH_ADDR = 6'h1C;
  localparam logic [5:0] BPM_CNT_LOW_ADDR     = 6'h20;
  localparam logic [5:0] BPM_CNT_HIGH_ADDR    = 6'h24;
  localparam logic [5:0] BPM_PWM_CTRL_ADDR    = 6'h28;
  localparam logic [5:0] BPM_MOTOR_CTRL_ADDR  = 6'h2C;
  localparam logic [5:0] BPM_STATUS_ADDR      = 6'h30;
  localparam logic [5:0] BPM_CMD_ADDR         = 6'h34;
  // Motor function control fields
  localparam int unsigned BPM_MFC_SIDE_BIT    = 0;
  localparam int unsigned BPM_MFC_PROT_BIT    = 1;
  localparam int unsigned BPM_MFC_GATE_BIT    = 2;
  localparam int unsigned BPM_MFC_COMPL_BIT   = 3;
  localparam int unsigned BPM_MFC_SRC_BIT     = 7;
  localparam logic [7:0]  BPM_MFC_RESET       = 8'h04;
  localparam logic [7:0]  BPM_MFC_MASK        = 8'h8F;
  // PWM control fields
  localparam int unsigned BPM_PC_RELOAD_BIT   = 0;
  localparam int unsigned BPM_PC_ON_BIT       = 3;
  localparam int unsigned BPM_PC_DIV_LSB      = 4;
  localparam int unsigned BPM_PC_ALIGN_BIT    = 7;
  localparam logic [7:0]  BPM_PC_RESET        = 8'h00;
  // Command word: bits 5..0 commands, bit 6 protect, bit 7 brake
  localparam int unsigned BPM_CMD_PROT_BIT    = 6;
  localparam int unsigned BPM_CMD_BRAKE_BIT   = 7;
  localparam logic [9:0]  BPM_ZERO10          = 10'h000;
  localparam logic [9:0]  BPM_ONE10           = 10'h001;
  localparam logic [2:0]  BPM_DIV_ONE         = 3'h0;

  typedef enum logic [2:0]
  {
    BPM_MODE_NORMAL  = 3'b001,
    BPM_MODE_BRAKE   = 3'b010,
    BPM_MODE_PROTECT = 3'b100
  } bpm_mode_type;

  typedef struct packed
  {
    logic [2:0] high;
    logic [2:0] low;
  } bpm_gate_type;
endpackage

// >>> hw/bpm_top.sv
// Three-phase PWM generator and hardware mask stage with Avalon-MM slave
// How it works
// RULE_01 - Duty high byte write-only, bits 9..8
// RULE_02 - Period is 10-bit write-only, cleared
// RULE_03 - Counter readable as two read-only bytes
// RULE_04 - Edge mode: period+1 clocks, duty clocks
// RULE_05 - Center mode: 2*period, 2*duty-1 clocks
// RULE_06 - Mask modes normal, brake, protect
// RULE_07 - Side select picks low or high PWM
// RULE_08 - Output gate off blocks all PWM
// RULE_09 - Complement select only in hardware mask
// RULE_10 - Mask source selects hardware or software; software path is not built, gates stay off in normal mode
// RULE_11 - Protect: highs zero, lows follow choice
// RULE_12 - Status shows gate outputs and halls; the code shows only gate_high_o[0], gate_low_o[0] and gate_high_o[1]
// RULE_13 - Complementary command table per phase
// RULE_14 - Non-complementary command table per phase
// RULE_15 - High byte buffers, low byte commits
// RULE_16 - Counter clock divides by 1,2,4,8
// RULE_17 - Reload only at wrap when enabled
// RULE_18 - High readback matches last low read
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module bpm_top
  import bpm_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [BPM_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  output logic      [1:0]            avs_response_o,
  input  wire logic [2:0]            filtered_hall_i,
  output logic      [2:0]            gate_high_o,
  output logic      [2:0]            gate_low_o
);

  logic [9:0]       duty_value [3];
  logic [9:0]       duty_active [3];
  logic [1:0]       duty_high_byte [3];
  logic [9:0]       period_value;
  logic [9:0]       period_active;
  logic [1:0]       period_high_byte;
  logic [9:0]       counter;
  logic             count_down;
  logic [1:0]       counter_high_readback;
  logic [7:0]       pwm_ctrl;
  logic [7:0]       motor_function_control;
  logic [7:0]       cmd_word;
  logic [2:0]       div_count;
  logic [2:0]       div_limit;
  logic             tick;
  logic             wrap;
  logic [2:0]       pwm_true_signal;
  logic             ack;
  logic             acc;
  logic             wr_ok;
  logic             rd_ok;
  logic [7:0]       wbyte;
  bpm_mode_type     mode;
  bpm_gate_type     next_gate;
  logic [2:0]       hall;

  // One wait cycle per access keeps the slave timing fixed
  assign acc   = (avs_read_i | avs_write_i) & ~ack;
  assign wr_ok = avs_write_i & ack & avs_byteenable_i[0];
  assign rd_ok = avs_read_i & acc;
  assign wbyte = avs_writedata_i[7:0];

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ack <= 1'b0;
    else
      ack <= acc;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~acc;
  end

  // Duty registers: high byte buffered, low byte commits both
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_duty
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          duty_high_byte[g] <= 2'h0; // RULE_01
          duty_value[g]     <= BPM_ZERO10;
        end
        else if (wr_ok)
        begin
          if (avs_address_i == BPM_DUTY0_HIGH_ADDR + 6'(8 * g))
            duty_high_byte[g] <= wbyte[1:0]; // RULE_15
          else if (avs_address_i == BPM_DUTY0_LOW_ADDR + 6'(8 * g))
            duty_value[g] <= {duty_high_byte[g], wbyte}; // RULE_15
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          duty_active[g] <= BPM_ZERO10;
        else if (pwm_ctrl[BPM_PC_RELOAD_BIT] && wrap)
          duty_active[g] <= duty_value[g]; // RULE_17
      end

      // Center mode passes zero once per period, so one compare gives
      // duty ticks in edge mode and twice duty less one in center mode
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          pwm_true_signal[g] <= 1'b0;
        else
          pwm_true_signal[g] <= counter < duty_active[g]; // RULE_04 RULE_05
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      period_high_byte <= 2'h0;
      period_value     <= BPM_ZERO10; // RULE_02
    end
    else if (wr_ok)
    begin
      if (avs_address_i == BPM_PERIOD_HIGH_ADDR)
        period_high_byte <= wbyte[1:0]; // RULE_15
      else if (avs_address_i == BPM_PERIOD_LOW_ADDR)
        period_value <= {period_high_byte, wbyte}; // RULE_15
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      period_active <= BPM_ZERO10;
    else if (pwm_ctrl[BPM_PC_RELOAD_BIT] && wrap)
      period_active <= period_value; // RULE_17
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pwm_ctrl               <= BPM_PC_RESET;
      motor_function_control <= BPM_MFC_RESET;
      cmd_word               <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (avs_address_i == BPM_PWM_CTRL_ADDR)
        pwm_ctrl <= wbyte;
      else if (avs_address_i == BPM_MOTOR_CTRL_ADDR)
        motor_function_control <= wbyte & BPM_MFC_MASK;
      else if (avs_address_i == BPM_CMD_ADDR)
        cmd_word <= wbyte;
    end
  end

  // Counter clock divider
  always_comb
  begin
    case (pwm_ctrl[BPM_PC_DIV_LSB +: 2]) // RULE_16
      2'h0:    div_limit = 3'h0;
      2'h1:    div_limit = 3'h1;
      2'h2:    div_limit = 3'h3;
      default: div_limit = 3'h7;
    endcase
  end

  assign tick = pwm_ctrl[BPM_PC_ON_BIT] && (div_count >= div_limit);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_count <= BPM_DIV_ONE;
    else if (!pwm_ctrl[BPM_PC_ON_BIT] || div_count >= div_limit)
      div_count <= BPM_DIV_ONE;
    else
      div_count <= div_count + 3'h1;
  end

  // Wrap marks overflow in edge mode and underflow in center mode
  assign wrap = tick && (pwm_ctrl[BPM_PC_ALIGN_BIT]
                  ? (count_down && counter <= BPM_ONE10)
                  : (counter >= period_active));

  // A zero period is illegal; the counter then sits at zero in edge mode and toggles between 0 and 1 in center mode
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      counter    <= BPM_ZERO10; // RULE_03
      count_down <= 1'b0;
    end
    else if (!pwm_ctrl[BPM_PC_ON_BIT])
    begin
      counter    <= BPM_ZERO10;
      count_down <= 1'b0;
    end
    else if (tick)
    begin
      if (!pwm_ctrl[BPM_PC_ALIGN_BIT])
      begin
        count_down <= 1'b0;
        counter <= wrap ? BPM_ZERO10 : counter + BPM_ONE10; // RULE_04
      end
      else if (!count_down)
      begin
        // RULE_05
        if (counter + BPM_ONE10 >= period_active)
          count_down <= 1'b1;
        counter <= counter + BPM_ONE10;
      end
      else
      begin
        if (counter <= BPM_ONE10)
          count_down <= 1'b0;
        counter <= counter - BPM_ONE10;
      end
    end
  end

  // Mode selection, brake over protect over normal
  always_comb
  begin
    if (cmd_word[BPM_CMD_BRAKE_BIT])
      mode = BPM_MODE_BRAKE; // RULE_06
    else if (cmd_word[BPM_CMD_PROT_BIT])
      mode = BPM_MODE_PROTECT;
    else
      mode = BPM_MODE_NORMAL;
  end

  // Per-phase hardware mask decode
  generate
    for (g = 0; g < 3; g++)
    begin : g_mask
      logic       pwm_on;
      logic       pwm_bar;
      logic [1:0] phase_cmd;
      assign phase_cmd = cmd_word[2*g +: 2];
      // RULE_08
      assign pwm_on  = pwm_true_signal[g] &
                       motor_function_control[BPM_MFC_GATE_BIT];
      // RULE_09
      assign pwm_bar = ~pwm_on & ~motor_function_control[BPM_MFC_COMPL_BIT]
                       & motor_function_control[BPM_MFC_GATE_BIT];
      always_comb
      begin
        next_gate.high[g] = 1'b0;
        next_gate.low[g]  = 1'b0;
        case (mode)
          BPM_MODE_BRAKE:
            next_gate.low[g] = 1'b1;
          BPM_MODE_PROTECT:
            next_gate.low[g] = motor_function_control[BPM_MFC_PROT_BIT];
            // RULE_11
          default:
          begin
            // Software mask path is not built; outputs stay off there
            if (!motor_function_control[BPM_MFC_SRC_BIT]) // RULE_10
            begin
              if (!motor_function_control[BPM_MFC_SIDE_BIT]) // RULE_07
              begin
                if (phase_cmd == 2'b01)
                begin
                  next_gate.high[g] = pwm_bar; // RULE_13
                  next_gate.low[g]  = pwm_on; // RULE_14
                end
                else if (phase_cmd == 2'b10)
                  next_gate.high[g] = 1'b1;
              end
              else
              begin
                if (phase_cmd == 2'b01)
                  next_gate.low[g] = 1'b1;
                else if (phase_cmd == 2'b10)
                begin
                  next_gate.high[g] = pwm_on; // RULE_14
                  next_gate.low[g]  = pwm_bar; // RULE_13
                end
              end
            end
          end
        endcase
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      {gate_high_o, gate_low_o} <= 6'h00;
    else
      {gate_high_o, gate_low_o} <= next_gate;
  end

  // Hall inputs are registered once; reset value is not meaningful
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hall <= 3'h0;
    else
      hall <= filtered_hall_i; // RULE_12
  end

  // Reading the low byte freezes the high bits of the same sample
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      counter_high_readback <= 2'h0;
    else if (rd_ok && avs_address_i == BPM_CNT_LOW_ADDR)
      counter_high_readback <= counter[9:8]; // RULE_18
  end

  // Read path; write-only registers read as zero
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end
    else if (rd_ok)
    begin
      avs_response_o <= 2'h0;
      if (avs_address_i == BPM_CNT_LOW_ADDR)
        avs_readdata_o <= {24'h000000, counter[7:0]}; // RULE_03
      else if (avs_address_i == BPM_CNT_HIGH_ADDR)
        avs_readdata_o <= {30'h0, counter_high_readback}; // RULE_18
      else if (avs_address_i == BPM_PWM_CTRL_ADDR)
        avs_readdata_o <= {24'h000000, pwm_ctrl};
      else if (avs_address_i == BPM_MOTOR_CTRL_ADDR)
        avs_readdata_o <= {24'h000000, motor_function_control};
      else if (avs_address_i == BPM_STATUS_ADDR)
        avs_readdata_o <= {26'h0, gate_high_o[0], gate_low_o[0],
                           gate_high_o[1], hall}; // RULE_12
      else if (avs_address_i == BPM_CMD_ADDR)
        avs_readdata_o <= {24'h000000, cmd_word};
      else if (avs_address_i <= BPM_PERIOD_HIGH_ADDR)
        avs_readdata_o <= 32'h0000_0000; // RULE_01
      else
      begin
        avs_readdata_o <= 32'h0000_0000;
        avs_response_o <= 2'h2;
      end
    end
    else if (acc)
      avs_response_o <= 2'h0;
  end

endmodule

// >>> test/bpm_checker.sv
// Port assertions for the PWM mask block
`timescale 1ns/1ps
module bpm_checker
  import bpm_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  reset_n_i,
  input wire logic [BPM_ADDR_W-1:0] avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [31:0]           avs_writedata_i,
  input wire logic [3:0]            avs_byteenable_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire logic [2:0]            gate_high_o,
  input wire logic [2:0]            gate_low_o
);
  logic [7:0] mfc;
  logic [7:0] cmd;
  logic [1:0] age;
  logic       wack;
  logic       rack;
  logic       set;
  logic       ok;
  assign wack = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign rack = avs_read_i & ~avs_waitrequest_o;
  assign set  = (age == 2'h3);
  assign ok   = set && (cmd[7:6] == 2'h0) && !wack;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of the mode registers; age lets the gate pipeline settle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mfc <= BPM_MFC_RESET;
      cmd <= 8'h00;
      age <= 2'h0;
    end
    else if (wack && avs_address_i == BPM_MOTOR_CTRL_ADDR)
    begin
      mfc <= avs_writedata_i[7:0];
      age <= 2'h0;
    end
    else if (wack && avs_address_i == BPM_CMD_ADDR)
    begin
      cmd <= avs_writedata_i[7:0];
      age <= 2'h0;
    end
    else if (!set)
      age <= age + 2'h1;
  end
  sequence s_take;
    (avs_read_i | avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_idle;
    !(avs_read_i | avs_write_i);
  endsequence
  AST_ONE_WAIT:
    assert property (s_take |=> !avs_waitrequest_o)
      else $error("request not answered after one wait");
  AST_NO_ACK:
    assert property (s_idle |=> avs_waitrequest_o)
      else $error("answer without a request");
  AST_WO_ZERO:
    assert property (rack && avs_address_i < BPM_CNT_LOW_ADDR
      |-> avs_readdata_o == 32'h0) else $error("write-only reads nonzero");
  AST_CNT_HIGH:
    assert property (rack && avs_address_i == BPM_CNT_HIGH_ADDR
      |-> avs_readdata_o[31:2] == 30'h0) else $error("counter high too wide");
  AST_BRAKE:
    assert property (set && cmd[7] |-> gate_high_o == 3'h0
      && gate_low_o == 3'h7) else $error("brake levels wrong");
  AST_PROTECT:
    assert property (set && cmd[7:6] == 2'h1 |-> gate_high_o == 3'h0
      && gate_low_o == {3{mfc[1]}}) else $error("protect levels wrong");
  AST_SW_MASK:
    assert property (ok && mfc[7] |-> {gate_high_o, gate_low_o} == 6'h00)
      else $error("software mask mode drives gates");
  AST_GATE_OFF:
    assert property (ok && !mfc[2] |=> $stable(gate_high_o)
      && $stable(gate_low_o)) else $error("gates switch while gated off");
  AST_NO_SHOOT:
    assert property ((gate_high_o & gate_low_o) == 3'h0)
      else $error("both sides of a phase on");
endmodule
bind bpm_top bpm_checker u_chk
(
  .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .gate_high_o(gate_high_o), .gate_low_o(gate_low_o)
);

// >>> test/bpm_gate_model.sv
// Gate driver model that flags any phase switched on at both sides
`timescale 1ns/1ps
module bpm_gate_model
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] high_i,
  input  wire logic [2:0] low_i,
  output logic            fault_o
);
  // Sticky: one overlap is enough to destroy a bridge leg
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      fault_o <= 1'b0;
    else if ((high_i & low_i) != 3'h0)
      fault_o <= 1'b1;
  end
endmodule

// >>> test/bpm_top_tb.sv
// Self-checking bench for the PWM mask block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, a, e); end end
module bpm_top_tb;
  import bpm_pkg::*;
  logic                  clk_i;
  logic                  reset_n_i;
  logic [BPM_ADDR_W-1:0] avs_address_i;
  logic                  avs_read_i;
  logic                  avs_write_i;
  logic [31:0]           avs_writedata_i;
  logic [3:0]            avs_byteenable_i;
  logic [31:0]           avs_readdata_o;
  logic                  avs_waitrequest_o;
  logic [1:0]            avs_response_o;
  logic [2:0]            filtered_hall_i;
  logic [2:0]            gate_high_o;
  logic [2:0]            gate_low_o;
  logic                  fault;
  logic [31:0]           q;
  logic [1:0]            r;
  logic [7:0]            m;
  logic [7:0]            c;
  logic [7:0]            lo;
  logic [2:0]            h;
  logic [5:0]            g;
  logic [9:0]            p;
  logic [9:0]            d;
  int                    t;
  int                    hi;
  int                    bad_count;
  int                    tests_run;
  bpm_top dut
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .filtered_hall_i(filtered_hall_i),
    .gate_high_o(gate_high_o), .gate_low_o(gate_low_o)
  );
  bpm_gate_model u_drv
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .high_i(gate_high_o),
    .low_i(gate_low_o), .fault_o(fault)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Idle edge first, so a release and a new request never share a step
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h000000, v};
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 40);
    q = avs_readdata_o;
    r = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (avs_waitrequest_o !== 1'b0)
    begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic wr10(input logic [5:0] a, input logic [9:0] v);
    bus(1'b1, a + 6'h04, {6'h00, v[9:8]});
    bus(1'b1, a, v[7:0]);
  endtask
  // Counts over whole periods, so the phase of the window does not matter
  task automatic meas(input int len, input int e);
    int n;
    n = 0;
    repeat (1200) @(posedge clk_i);
    repeat (len) @(posedge clk_i) n += int'(gate_low_o[0]);
    `CHK(n, e)
  endtask
  // Static gate levels with the PWM held low (duty still zero)
  function automatic logic [5:0] gexp(input logic [7:0] k, input logic [7:0] f);
    logic [5:0] o;
    logic [1:0] v;
    o = 6'h00;
    if (k[7])
      return 6'h07;
    if (k[6])
      return {3'h0, {3{f[1]}}};
    for (int i = 0; i < 3; i++)
    begin
      v = k[2*i+:2];
      if (f[7] || v == 2'h0 || v == 2'h3)
        v = 2'h0;
      else if (f[0])
        v = v[0] ? 2'h1 : {1'b0, f[2] & ~f[3]};
      else
        v = v[1] ? 2'h2 : {f[2] & ~f[3], 1'b0};
      o[3+i] = v[1];
      o[i]   = v[0];
    end
    return o;
  endfunction
  initial
  begin
    reset_n_i        = 1'b0;
    avs_address_i    = 6'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'hF;
    filtered_hall_i  = 3'h0;
    bad_count        = 0;
    tests_run        = 0;
    void'($urandom(32'h22F1));
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus(1'b0, BPM_MOTOR_CTRL_ADDR, 8'h00);
    `CHK(q[7:0], BPM_MFC_RESET)
    avs_byteenable_i <= 4'hE;
    bus(1'b1, BPM_MOTOR_CTRL_ADDR, 8'h00);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, BPM_MOTOR_CTRL_ADDR, 8'h00);
    `CHK(q[7:0], BPM_MFC_RESET)
    for (int a = 0; a < 10; a++)
    begin
      bus(1'b0, 6'(4 * a), 8'h00);
      `CHK(q, 32'h0)
    end
    bus(1'b0, 6'h3C, 8'h00);
    `CHK(r, 2'h2)
    for (int i = 0; i < 24; i++)
    begin
      m = 8'($urandom) & BPM_MFC_MASK;
      m[2] = (i % 3 != 0);
      c = 8'($urandom) & 8'h3F;
      c[7] = (i % 8 == 1);
      c[6] = (i % 4 == 2);
      h = 3'($urandom);
      filtered_hall_i <= h;
      bus(1'b1, BPM_MOTOR_CTRL_ADDR, m);
      bus(1'b1, BPM_CMD_ADDR, c);
      bus(1'b0, BPM_MOTOR_CTRL_ADDR, 8'h00);
      `CHK(q[7:0], m)
      bus(1'b0, BPM_STATUS_ADDR, 8'h00);
      g = gexp(c, m);
      `CHK({gate_high_o, gate_low_o}, g)
      `CHK(q[7:0], {2'h0, g[3], g[0], g[4], h})
      `CHK(r, 2'h0)
    end
    bus(1'b1, BPM_MOTOR_CTRL_ADDR, 8'h04);
    bus(1'b1, BPM_CMD_ADDR, 8'h01);
    for (int k = 0; k < 8; k++)
    begin
      p = 10'((k[1:0] == 2'h0) ? $urandom_range(270, 250)
                               : $urandom_range(12, 4));
      d = 10'($urandom_range(p, 1));
      wr10(BPM_PERIOD_LOW_ADDR, p);
      wr10(BPM_DUTY0_LOW_ADDR, d);
      bus(1'b1, BPM_PWM_CTRL_ADDR, {k[2], 1'b0, k[1:0], 4'h9});
      t = (k[2] ? 2 * p : p + 1) << k[1:0];
      hi = (k[2] ? 2 * d - 1 : d) << k[1:0];
      meas(2 * t, 2 * hi);
      bus(1'b0, BPM_CNT_LOW_ADDR, 8'h00);
      lo = q[7:0];
      bus(1'b0, BPM_CNT_HIGH_ADDR, 8'h00);
      `CHK({q[1:0], lo} <= p, 1'b1)
    end
    bus(1'b1, BPM_PWM_CTRL_ADDR, 8'hB8);
    wr10(BPM_DUTY0_LOW_ADDR, d ^ 10'h001);
    meas(2 * t, 2 * hi);
    bus(1'b1, BPM_MOTOR_CTRL_ADDR, 8'h00);
    meas(2 * t, 0);
    `CHK(fault, 1'b0)
    final_report();
  end
endmodule
